// ===== src/dcir_regs.svh
// register map, field positions and sizes of the interrupt routing block
`ifndef DCIR_REGS_SVH
`define DCIR_REGS_SVH
`define DCIR_NUM_SRC 168
`define DCIR_SRC_WORDS 6
`define DCIR_SEC_LINES 8
`define DCIR_SW_LINES 8
`define DCIR_SEC_ALL 16
`define DCIR_NMI_SLOTS 4
`define DCIR_WAKE_SRC 39
`define DCIR_WAKE_HI_W 7
`define DCIR_IPC_NUM 16
`define DCIR_MAIN_PRIO_W 3
`define DCIR_SEC_PRIO_W 2
`define DCIR_PRIO_NIB 4
`define DCIR_PRIO_PER_WORD 8
`define DCIR_MAIN_PRIO_WORDS 21
`define DCIR_SEL_W 8
`define DCIR_ADDR_W 12
`define DCIR_WORD_W 32
`define DCIR_RST_WORD 32'h0000_0000
// address fields
`define DCIR_PAGE_HI 11
`define DCIR_PAGE_LO 8
`define DCIR_IDX_HI 7
`define DCIR_IDX_LO 4
`define DCIR_SUB_HI 3
`define DCIR_SUB_LO 2
`define DCIR_WORD_HI 7
`define DCIR_WORD_LO 2
`define DCIR_LINE_HI 7
`define DCIR_LINE_LO 5
`define DCIR_MWORD_HI 4
`define DCIR_MWORD_LO 2
// pages
`define DCIR_PAGE_MISC 4'h0
`define DCIR_PAGE_SEC_MAP 4'h1
`define DCIR_PAGE_IPC_CHAN 4'h2
`define DCIR_PAGE_IPC_STRUCT 4'h3
// single registers in the misc page (main priority words sit at 0x000..0x050)
`define DCIR_A_SEC_PRIO 12'h080
`define DCIR_A_SW_SET 12'h084
`define DCIR_A_SW_CLR 12'h088
`define DCIR_A_MAIN_NMI_SEL 12'h08c
`define DCIR_A_MAIN_NMI_EN 12'h090
`define DCIR_A_SEC_NMI_SEL 12'h094
`define DCIR_A_SEC_NMI_EN 12'h098
`define DCIR_A_WAKE_LO 12'h09c
`define DCIR_A_WAKE_HI 12'h0a0
`define DCIR_A_SYSCALL 12'h0a4
`define DCIR_A_SYSCALL_CLR 12'h0a8
`define DCIR_A_STATUS 12'h0ac
// word within an ipc channel
`define DCIR_CH_ACQUIRE 2'h0
`define DCIR_CH_RELEASE 2'h1
`define DCIR_CH_DATA 2'h2
`define DCIR_CH_NOTIFY 2'h3
// word within an ipc interrupt structure
`define DCIR_ST_PEND 2'h0
`define DCIR_ST_MASK 2'h1
`define DCIR_ST_TARGET 2'h2
// data fields
`define DCIR_ST_ID_HI 3
`define DCIR_ST_ID_LO 0
`define DCIR_REL_SIG_BIT 4
`define DCIR_NOTIFY_BIT 0
`define DCIR_REL_BIT 1
`define DCIR_CMD_BIT 0
`endif

// ===== src/dcir_pkg.sv
// types shared by the interrupt routing block
`include "dcir_regs.svh"
package dcir_pkg;
  typedef enum logic {
    DCIR_CORE_MAIN = 1'b0,
    DCIR_CORE_SEC = 1'b1
  } dcir_core_type;
  typedef struct packed {
    logic valid;
    logic [7:0] id;
    logic [`DCIR_MAIN_PRIO_W-1:0] prio;
  } dcir_main_best_type;
  typedef struct packed {
    logic valid;
    logic [3:0] id;
    logic [`DCIR_SEC_PRIO_W-1:0] prio;
  } dcir_sec_best_type;
  typedef struct packed {
    logic locked;
    dcir_core_type owner;
  } dcir_lock_type;
  typedef struct packed {
    logic rel;
    logic notify;
  } dcir_ipc_pend_type;
endpackage

// ===== src/dcir_ipc_chan.sv
// one inter-core messaging channel: lock and data word
`timescale 1ns/1ps
`include "dcir_regs.svh"
module dcir_ipc_chan (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic acquire_i,
  input wire logic release_i,
  input wire logic data_we_i,
  input wire dcir_pkg::dcir_core_type core_i,
  input wire logic [`DCIR_WORD_W-1:0] wdata_i,
  output logic grant_o,
  output logic rel_ok_o,
  output dcir_pkg::dcir_lock_type lock_o,
  output logic [`DCIR_WORD_W-1:0] data_o
);
  dcir_pkg::dcir_lock_type lock_reg, lock_next;
  logic [`DCIR_WORD_W-1:0] data_reg, data_next;
  wire logic owns = lock_reg.locked && (lock_reg.owner == core_i);

  // test and set in the same access, one bus so no race
  assign grant_o = acquire_i && !lock_reg.locked;
  assign rel_ok_o = release_i && owns;
  // foreign releases are ignored so a lock cannot be stolen
  assign lock_next = grant_o ? dcir_pkg::dcir_lock_type'{locked: 1'b1, owner: core_i} :
                     rel_ok_o ? dcir_pkg::dcir_lock_type'{locked: 1'b0,
                                                        owner: dcir_pkg::DCIR_CORE_MAIN} :
                     lock_reg;
  // only the lock holder may change the payload
  assign data_next = (data_we_i && owns) ? wdata_i : data_reg;
  assign lock_o = lock_reg;
  assign data_o = data_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      lock_reg <= '{locked: 1'b0, owner: dcir_pkg::DCIR_CORE_MAIN};
      data_reg <= `DCIR_RST_WORD;
    end else begin
      lock_reg <= lock_next;
      data_reg <= data_next;
    end
  end
endmodule

// ===== src/dcir_top.sv
// interrupt routing, nmi, wake and inter-core messaging for two cores
// Operation
// - all 168 sources go straight to main lines
// - eight secondary lines, any sources mapped each
// - eight secondary interrupts raised by software only
// - priorities: eight levels main, four secondary
// - up to four sources drive each nmi
// - 39 sources can wake from deep sleep
// - sixteen channels and sixteen interrupt structures
// - each channel has a single-owner lock
// - interrupt structure lets one core interrupt other
// - structures signal notify and channel release
// - system call request raises secondary nmi
`timescale 1ns/1ps
`include "dcir_regs.svh"
module dcir_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`DCIR_NUM_SRC-1:0] irq_src_i,
  input wire logic dbg_syscall_req_i,
  input wire logic deep_sleep_i,
  input wire logic [`DCIR_ADDR_W-1:0] bus_addr_i,
  input wire logic [`DCIR_WORD_W-1:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire dcir_pkg::dcir_core_type bus_core_i,
  output logic [`DCIR_WORD_W-1:0] bus_rdata_o,
  output logic [`DCIR_NUM_SRC-1:0] main_cpu_irq_o,
  output dcir_pkg::dcir_main_best_type main_cpu_best_o,
  output logic main_cpu_nmi_o,
  output logic [`DCIR_SEC_LINES-1:0] secondary_cpu_irq_o,
  output logic [`DCIR_SW_LINES-1:0] secondary_cpu_sw_irq_o,
  output dcir_pkg::dcir_sec_best_type secondary_cpu_best_o,
  output logic secondary_cpu_nmi_o,
  output logic wake_o,
  output logic [`DCIR_IPC_NUM-1:0] main_cpu_ipc_irq_o,
  output logic [`DCIR_IPC_NUM-1:0] secondary_cpu_ipc_irq_o
);
  // decoding helpers
  function automatic logic hit(input logic [`DCIR_ADDR_W-1:0] a,
                               input logic [`DCIR_ADDR_W-1:0] r);
    hit = (a[`DCIR_ADDR_W-1:`DCIR_WORD_LO] == r[`DCIR_ADDR_W-1:`DCIR_WORD_LO]);
  endfunction

  function automatic logic pick(input logic [`DCIR_NUM_SRC-1:0] src,
                                input logic [`DCIR_SEL_W-1:0] idx);
    // out of range selects read as quiet rather than wrapping
    pick = (idx < 8'(`DCIR_NUM_SRC)) ? src[idx] : 1'b0;
  endfunction

  function automatic dcir_pkg::dcir_main_best_type best_main(
      input logic [`DCIR_NUM_SRC-1:0] pend,
      input logic [`DCIR_NUM_SRC*`DCIR_MAIN_PRIO_W-1:0] prio);
    dcir_pkg::dcir_main_best_type b;
    b = '0;
    // lower value wins, lower id breaks ties
    for (int i = 0; i < `DCIR_NUM_SRC; i++) begin
      if (pend[i] && (!b.valid || prio[i*`DCIR_MAIN_PRIO_W +: `DCIR_MAIN_PRIO_W] < b.prio)) begin
        b.valid = 1'b1;
        b.id = 8'(i);
        b.prio = prio[i*`DCIR_MAIN_PRIO_W +: `DCIR_MAIN_PRIO_W];
      end
    end
    best_main = b;
  endfunction

  function automatic dcir_pkg::dcir_sec_best_type best_sec(
      input logic [`DCIR_SEC_ALL-1:0] pend,
      input logic [`DCIR_SEC_ALL*`DCIR_SEC_PRIO_W-1:0] prio);
    dcir_pkg::dcir_sec_best_type b;
    b = '0;
    for (int i = 0; i < `DCIR_SEC_ALL; i++) begin
      if (pend[i] && (!b.valid || prio[i*`DCIR_SEC_PRIO_W +: `DCIR_SEC_PRIO_W] < b.prio)) begin
        b.valid = 1'b1;
        b.id = 4'(i);
        b.prio = prio[i*`DCIR_SEC_PRIO_W +: `DCIR_SEC_PRIO_W];
      end
    end
    best_sec = b;
  endfunction

  // state
  logic [`DCIR_MAIN_PRIO_W-1:0] main_prio_reg [`DCIR_NUM_SRC];
  logic [`DCIR_WORD_W-1:0] sec_map_reg [`DCIR_SEC_LINES][`DCIR_SRC_WORDS];
  logic [`DCIR_WORD_W-1:0] sec_prio_reg;
  logic [`DCIR_SW_LINES-1:0] sw_pend_reg, sw_pend_next;
  logic [`DCIR_WORD_W-1:0] main_nmi_sel_reg, sec_nmi_sel_reg;
  logic [`DCIR_NMI_SLOTS-1:0] main_nmi_en_reg, sec_nmi_en_reg;
  logic [`DCIR_WAKE_SRC-1:0] wake_mask_reg;
  logic syscall_reg, syscall_next;
  dcir_pkg::dcir_ipc_pend_type st_pend_reg [`DCIR_IPC_NUM];
  dcir_pkg::dcir_ipc_pend_type st_mask_reg [`DCIR_IPC_NUM];
  dcir_pkg::dcir_core_type st_target_reg [`DCIR_IPC_NUM];
  logic [`DCIR_WORD_W-1:0] rdata_reg, rdata_next;
  logic [`DCIR_NUM_SRC-1:0] main_irq_reg;
  dcir_pkg::dcir_main_best_type main_best_reg, main_best_next;
  dcir_pkg::dcir_sec_best_type sec_best_reg, sec_best_next;
  logic [`DCIR_SEC_LINES-1:0] sec_irq_reg;
  logic main_nmi_reg, sec_nmi_reg, wake_reg;
  logic [`DCIR_IPC_NUM-1:0] main_ipc_reg, sec_ipc_reg;
  logic [`DCIR_IPC_NUM-1:0] main_ipc_next, sec_ipc_next;

  // address decode
  wire logic [3:0] page = bus_addr_i[`DCIR_PAGE_HI:`DCIR_PAGE_LO];
  wire logic [5:0] word = bus_addr_i[`DCIR_WORD_HI:`DCIR_WORD_LO];
  wire logic [3:0] idx = bus_addr_i[`DCIR_IDX_HI:`DCIR_IDX_LO];
  wire logic [1:0] sub = bus_addr_i[`DCIR_SUB_HI:`DCIR_SUB_LO];
  wire logic [2:0] map_line = bus_addr_i[`DCIR_LINE_HI:`DCIR_LINE_LO];
  wire logic [2:0] map_word = bus_addr_i[`DCIR_MWORD_HI:`DCIR_MWORD_LO];
  wire logic pg_misc = (page == `DCIR_PAGE_MISC);
  wire logic pg_map = (page == `DCIR_PAGE_SEC_MAP);
  wire logic pg_chan = (page == `DCIR_PAGE_IPC_CHAN);
  wire logic pg_st = (page == `DCIR_PAGE_IPC_STRUCT);
  wire logic in_prio = pg_misc && (word < 6'(`DCIR_MAIN_PRIO_WORDS));
  wire logic in_map = pg_map && (map_word < 3'(`DCIR_SRC_WORDS));
  wire logic wr_sw_set = bus_wr_i && hit(bus_addr_i, `DCIR_A_SW_SET);
  wire logic wr_sw_clr = bus_wr_i && hit(bus_addr_i, `DCIR_A_SW_CLR);
  wire logic wr_sys = bus_wr_i && hit(bus_addr_i, `DCIR_A_SYSCALL);
  wire logic wr_sys_clr = bus_wr_i && hit(bus_addr_i, `DCIR_A_SYSCALL_CLR);
  wire logic ch_notify = bus_wr_i && pg_chan && (sub == `DCIR_CH_NOTIFY);
  wire logic [3:0] st_id = bus_wdata_i[`DCIR_ST_ID_HI:`DCIR_ST_ID_LO];

  // main lines carry the source level one to one, only retimed
  wire logic [`DCIR_NUM_SRC*`DCIR_MAIN_PRIO_W-1:0] main_prio_flat;
  wire logic [`DCIR_WORD_W-1:0] main_prio_word [`DCIR_MAIN_PRIO_WORDS];
  genvar gi;
  generate
    for (gi = 0; gi < `DCIR_NUM_SRC; gi++) begin : g_mprio
      localparam int W = gi / `DCIR_PRIO_PER_WORD;
      localparam int N = gi % `DCIR_PRIO_PER_WORD;
      assign main_prio_flat[gi*`DCIR_MAIN_PRIO_W +: `DCIR_MAIN_PRIO_W] = main_prio_reg[gi];
      assign main_prio_word[W][N*`DCIR_PRIO_NIB +: `DCIR_PRIO_NIB] = {1'b0, main_prio_reg[gi]};
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          main_prio_reg[gi] <= '0;
        end else if (bus_wr_i && in_prio && (word == 6'(W))) begin
          main_prio_reg[gi] <= bus_wdata_i[N*`DCIR_PRIO_NIB +: `DCIR_MAIN_PRIO_W];
        end
      end
    end
  endgenerate
  assign main_best_next = best_main(irq_src_i, main_prio_flat);

  // secondary lines: or of every mapped source, so a line falls with its last source
  wire logic [`DCIR_SEC_LINES-1:0] sec_line;
  generate
    for (gi = 0; gi < `DCIR_SEC_LINES; gi++) begin : g_line
      wire logic [`DCIR_SRC_WORDS*`DCIR_WORD_W-1:0] map_flat;
      for (genvar w = 0; w < `DCIR_SRC_WORDS; w++) begin : g_word
        assign map_flat[w*`DCIR_WORD_W +: `DCIR_WORD_W] = sec_map_reg[gi][w];
        always_ff @(posedge sys_clk_i) begin
          if (!rst_n_i) begin
            sec_map_reg[gi][w] <= `DCIR_RST_WORD;
          end else if (bus_wr_i && in_map && map_line == 3'(gi) && map_word == 3'(w)) begin
            sec_map_reg[gi][w] <= bus_wdata_i;
          end
        end
      end
      assign sec_line[gi] = |(irq_src_i & map_flat[`DCIR_NUM_SRC-1:0]);
    end
  endgenerate

  // software lines: set and clear by write-one, set wins
  assign sw_pend_next = (sw_pend_reg & ~(wr_sw_clr ? bus_wdata_i[`DCIR_SW_LINES-1:0] : '0)) |
                        (wr_sw_set ? bus_wdata_i[`DCIR_SW_LINES-1:0] : '0);
  assign sec_best_next = best_sec({sw_pend_next, sec_line}, sec_prio_reg);

  // nmi slots: each slot is a source index plus an enable
  wire logic [`DCIR_NMI_SLOTS-1:0] main_slot, sec_slot;
  generate
    for (gi = 0; gi < `DCIR_NMI_SLOTS; gi++) begin : g_nmi
      assign main_slot[gi] = main_nmi_en_reg[gi] &&
                             pick(irq_src_i, main_nmi_sel_reg[gi*`DCIR_SEL_W +: `DCIR_SEL_W]);
      assign sec_slot[gi] = sec_nmi_en_reg[gi] &&
                            pick(irq_src_i, sec_nmi_sel_reg[gi*`DCIR_SEL_W +: `DCIR_SEL_W]);
    end
  endgenerate
  // system call pending until either core writes one to the clear register, request wins
  assign syscall_next = (syscall_reg && !(wr_sys_clr && bus_wdata_i[`DCIR_CMD_BIT])) ||
                        (wr_sys && bus_wdata_i[`DCIR_CMD_BIT]) || dbg_syscall_req_i;

  // inter-core channels
  logic [`DCIR_IPC_NUM-1:0] ch_grant, ch_rel_ok;
  dcir_pkg::dcir_lock_type ch_lock [`DCIR_IPC_NUM];
  logic [`DCIR_WORD_W-1:0] ch_data [`DCIR_IPC_NUM];
  generate
    for (gi = 0; gi < `DCIR_IPC_NUM; gi++) begin : g_chan
      wire logic sel = pg_chan && (idx == 4'(gi));
      dcir_ipc_chan u_chan (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .acquire_i(bus_rd_i && sel && (sub == `DCIR_CH_ACQUIRE)),
        .release_i(bus_wr_i && sel && (sub == `DCIR_CH_RELEASE)),
        .data_we_i(bus_wr_i && sel && (sub == `DCIR_CH_DATA)),
        .core_i(bus_core_i),
        .wdata_i(bus_wdata_i),
        .grant_o(ch_grant[gi]),
        .rel_ok_o(ch_rel_ok[gi]),
        .lock_o(ch_lock[gi]),
        .data_o(ch_data[gi])
      );
    end
  endgenerate
  // a release may carry a signal to a structure; a refused release signals nothing
  wire logic rel_sig = ch_rel_ok[idx] && bus_wdata_i[`DCIR_REL_SIG_BIT];

  // interrupt structures
  wire logic [`DCIR_IPC_NUM-1:0] st_hit;
  generate
    for (gi = 0; gi < `DCIR_IPC_NUM; gi++) begin : g_st
      wire logic me = pg_st && (idx == 4'(gi)) && bus_wr_i;
      wire logic clr_n = me && (sub == `DCIR_ST_PEND) && bus_wdata_i[`DCIR_NOTIFY_BIT];
      wire logic clr_r = me && (sub == `DCIR_ST_PEND) && bus_wdata_i[`DCIR_REL_BIT];
      wire logic set_n = ch_notify && (st_id == 4'(gi));
      wire logic set_r = rel_sig && (st_id == 4'(gi));
      dcir_pkg::dcir_ipc_pend_type pend_next;
      assign pend_next.notify = (st_pend_reg[gi].notify && !clr_n) || set_n;
      assign pend_next.rel = (st_pend_reg[gi].rel && !clr_r) || set_r;
      assign st_hit[gi] = |(st_pend_reg[gi] & st_mask_reg[gi]);
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          st_pend_reg[gi] <= '0;
          st_mask_reg[gi] <= '0;
          st_target_reg[gi] <= dcir_pkg::DCIR_CORE_MAIN;
        end else begin
          st_pend_reg[gi] <= pend_next;
          if (me && sub == `DCIR_ST_MASK) begin
            st_mask_reg[gi] <= bus_wdata_i[`DCIR_REL_BIT:`DCIR_NOTIFY_BIT];
          end
          if (me && sub == `DCIR_ST_TARGET) begin
            st_target_reg[gi] <= dcir_pkg::dcir_core_type'(bus_wdata_i[`DCIR_CMD_BIT]);
          end
        end
      end
      assign main_ipc_next[gi] = st_hit[gi] && (st_target_reg[gi] == dcir_pkg::DCIR_CORE_MAIN);
      assign sec_ipc_next[gi] = st_hit[gi] && (st_target_reg[gi] == dcir_pkg::DCIR_CORE_SEC);
    end
  endgenerate

  // read path, one cycle late; unmapped words read zero
  wire logic [`DCIR_WORD_W-1:0] rd_status = {12'h000, syscall_reg, sec_best_reg,
                                             main_best_reg};
  wire logic [`DCIR_WORD_W-1:0] rd_misc =
    in_prio ? main_prio_word[word[4:0]] :
    hit(bus_addr_i, `DCIR_A_SEC_PRIO) ? sec_prio_reg :
    (hit(bus_addr_i, `DCIR_A_SW_SET) || hit(bus_addr_i, `DCIR_A_SW_CLR)) ?
      {24'h000000, sw_pend_reg} :
    hit(bus_addr_i, `DCIR_A_MAIN_NMI_SEL) ? main_nmi_sel_reg :
    hit(bus_addr_i, `DCIR_A_MAIN_NMI_EN) ? {28'h0000000, main_nmi_en_reg} :
    hit(bus_addr_i, `DCIR_A_SEC_NMI_SEL) ? sec_nmi_sel_reg :
    hit(bus_addr_i, `DCIR_A_SEC_NMI_EN) ? {28'h0000000, sec_nmi_en_reg} :
    hit(bus_addr_i, `DCIR_A_WAKE_LO) ? wake_mask_reg[`DCIR_WORD_W-1:0] :
    hit(bus_addr_i, `DCIR_A_WAKE_HI) ?
      {25'h0000000, wake_mask_reg[`DCIR_WAKE_SRC-1:`DCIR_WORD_W]} :
    (hit(bus_addr_i, `DCIR_A_SYSCALL) || hit(bus_addr_i, `DCIR_A_SYSCALL_CLR)) ?
      {31'h00000000, syscall_reg} :
    hit(bus_addr_i, `DCIR_A_STATUS) ? rd_status : `DCIR_RST_WORD;
  // acquire answer: bit0 granted now, bit1 locked, bit2 owner
  wire logic [`DCIR_WORD_W-1:0] rd_chan =
    (sub == `DCIR_CH_ACQUIRE) ? {29'h00000000,
      ch_grant[idx] ? bus_core_i : ch_lock[idx].owner, ch_lock[idx].locked | ch_grant[idx],
      ch_grant[idx]} :
    (sub == `DCIR_CH_DATA) ? ch_data[idx] : `DCIR_RST_WORD;
  wire logic [`DCIR_WORD_W-1:0] rd_st =
    (sub == `DCIR_ST_PEND) ? {30'h00000000, st_pend_reg[idx]} :
    (sub == `DCIR_ST_MASK) ? {30'h00000000, st_mask_reg[idx]} :
    (sub == `DCIR_ST_TARGET) ? {31'h00000000, st_target_reg[idx]} : `DCIR_RST_WORD;
  assign rdata_next = !bus_rd_i ? `DCIR_RST_WORD :
                      pg_misc ? rd_misc :
                      in_map ? sec_map_reg[map_line][map_word] :
                      pg_chan ? rd_chan :
                      pg_st ? rd_st : `DCIR_RST_WORD;

  // configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sec_prio_reg <= `DCIR_RST_WORD;
      main_nmi_sel_reg <= `DCIR_RST_WORD;
      sec_nmi_sel_reg <= `DCIR_RST_WORD;
      main_nmi_en_reg <= '0;
      sec_nmi_en_reg <= '0;
      wake_mask_reg <= '0;
    end else if (bus_wr_i) begin
      if (hit(bus_addr_i, `DCIR_A_SEC_PRIO)) sec_prio_reg <= bus_wdata_i;
      if (hit(bus_addr_i, `DCIR_A_MAIN_NMI_SEL)) main_nmi_sel_reg <= bus_wdata_i;
      if (hit(bus_addr_i, `DCIR_A_SEC_NMI_SEL)) sec_nmi_sel_reg <= bus_wdata_i;
      if (hit(bus_addr_i, `DCIR_A_MAIN_NMI_EN)) begin
        main_nmi_en_reg <= bus_wdata_i[`DCIR_NMI_SLOTS-1:0];
      end
      if (hit(bus_addr_i, `DCIR_A_SEC_NMI_EN)) begin
        sec_nmi_en_reg <= bus_wdata_i[`DCIR_NMI_SLOTS-1:0];
      end
      if (hit(bus_addr_i, `DCIR_A_WAKE_LO)) begin
        wake_mask_reg[`DCIR_WORD_W-1:0] <= bus_wdata_i;
      end
      if (hit(bus_addr_i, `DCIR_A_WAKE_HI)) begin
        wake_mask_reg[`DCIR_WAKE_SRC-1:`DCIR_WORD_W] <= bus_wdata_i[`DCIR_WAKE_HI_W-1:0];
      end
    end
  end

  // output and pending flops
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      main_irq_reg <= '0;
      main_best_reg <= '0;
      sec_irq_reg <= '0;
      sw_pend_reg <= '0;
      sec_best_reg <= '0;
      syscall_reg <= 1'b0;
      main_nmi_reg <= 1'b0;
      sec_nmi_reg <= 1'b0;
      wake_reg <= 1'b0;
      main_ipc_reg <= '0;
      sec_ipc_reg <= '0;
      rdata_reg <= `DCIR_RST_WORD;
    end else begin
      main_irq_reg <= irq_src_i;
      main_best_reg <= main_best_next;
      sec_irq_reg <= sec_line;
      sw_pend_reg <= sw_pend_next;
      sec_best_reg <= sec_best_next;
      syscall_reg <= syscall_next;
      main_nmi_reg <= |main_slot;
      sec_nmi_reg <= (|sec_slot) || syscall_next;
      // sys_clk keeps running in deep sleep; only the cores stop
      wake_reg <= deep_sleep_i && |(irq_src_i[`DCIR_WAKE_SRC-1:0] & wake_mask_reg);
      main_ipc_reg <= main_ipc_next;
      sec_ipc_reg <= sec_ipc_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata_o = rdata_reg;
  assign main_cpu_irq_o = main_irq_reg;
  assign main_cpu_best_o = main_best_reg;
  assign main_cpu_nmi_o = main_nmi_reg;
  assign secondary_cpu_irq_o = sec_irq_reg;
  assign secondary_cpu_sw_irq_o = sw_pend_reg;
  assign secondary_cpu_best_o = sec_best_reg;
  assign secondary_cpu_nmi_o = sec_nmi_reg;
  assign wake_o = wake_reg;
  assign main_cpu_ipc_irq_o = main_ipc_reg;
  assign secondary_cpu_ipc_irq_o = sec_ipc_reg;
endmodule

// ===== verification/dcir_src_model.sv
// behavioural bank of peripheral interrupt sources
`timescale 1ns/1ps
`include "dcir_regs.svh"
module dcir_src_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] idx_i,
  input wire logic raise_i,
  input wire logic drop_i,
  output logic [`DCIR_NUM_SRC-1:0] irq_o
);
  // a source holds its level until serviced, like a real peripheral
  initial irq_o = '0;
  always @(posedge sys_clk_i) begin
    if (raise_i) irq_o[idx_i] <= 1'b1;
    if (drop_i) irq_o[idx_i] <= 1'b0;
  end
endmodule

// ===== verification/dcir_top_assertions.sv
// port checks of the routing block
`timescale 1ns/1ps
`include "dcir_regs.svh"
module dcir_top_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`DCIR_NUM_SRC-1:0] irq_src_i,
  input wire logic dbg_syscall_req_i,
  input wire logic deep_sleep_i,
  input wire logic [`DCIR_ADDR_W-1:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire dcir_pkg::dcir_core_type bus_core_i,
  input wire logic [`DCIR_WORD_W-1:0] bus_rdata_o,
  input wire logic [`DCIR_NUM_SRC-1:0] main_cpu_irq_o,
  input wire logic [`DCIR_SEC_LINES-1:0] secondary_cpu_irq_o,
  input wire logic [`DCIR_SW_LINES-1:0] secondary_cpu_sw_irq_o,
  input wire logic secondary_cpu_nmi_o,
  input wire logic wake_o,
  input wire logic [`DCIR_IPC_NUM-1:0] main_cpu_ipc_irq_o,
  input wire logic [`DCIR_IPC_NUM-1:0] secondary_cpu_ipc_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_main_follow: assert property ($past(rst_n_i) |-> main_cpu_irq_o == $past(irq_src_i))
    else $error("main line differs from source");
  a_sec_drop: assert property ($past(irq_src_i) == '0 |-> secondary_cpu_irq_o == '0)
    else $error("secondary line without source");
  a_sw_only: assert property ((secondary_cpu_sw_irq_o & ~$past(secondary_cpu_sw_irq_o)) != '0
    |-> $past(bus_wr_i) && $past(bus_addr_i) == `DCIR_A_SW_SET)
    else $error("software line rose without set write");
  a_wake_sleep: assert property (!$past(deep_sleep_i) |-> !wake_o)
    else $error("wake outside deep sleep");
  a_syscall_nmi: assert property ($past(rst_n_i) && $past(dbg_syscall_req_i)
    |-> secondary_cpu_nmi_o)
    else $error("system call did not raise nmi");
  a_ipc_one_core: assert property ((main_cpu_ipc_irq_o & secondary_cpu_ipc_irq_o) == '0)
    else $error("structure interrupts both cores");
  a_acq_report: assert property ($past(bus_rd_i) && $past(bus_addr_i[11:8]) == 4'h2
    && $past(bus_addr_i[3:2]) == 2'h0 && bus_rdata_o[0]
    |-> bus_rdata_o[2:1] == {$past(bus_core_i), 1'b1})
    else $error("grant without lock to reader");
  a_rdata_idle: assert property (!$past(bus_rd_i) |-> bus_rdata_o == '0)
    else $error("read data outside answer cycle");
endmodule
bind dcir_top dcir_top_assertions dcir_top_assertions_i (.*);

// ===== verification/dcir_top_tb_top.sv
// self-checking bench for the routing block
`timescale 1ns/1ps
`include "dcir_regs.svh"
module dcir_top_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic dbg_req = 1'b0;
  logic sleep = 1'b0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  dcir_pkg::dcir_core_type core = dcir_pkg::DCIR_CORE_MAIN;
  logic [7:0] s_idx = '0;
  logic s_up = 1'b0;
  logic s_dn = 1'b0;
  logic [167:0] src, main_irq;
  logic [31:0] rdata, got;
  dcir_pkg::dcir_main_best_type main_best;
  dcir_pkg::dcir_sec_best_type sec_best;
  logic main_nmi, sec_nmi, wake;
  logic [7:0] sec_irq, sw_irq;
  logic [15:0] m_ipc, s_ipc;
  int fail_count = 0;
  int num_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  dcir_src_model dcir_src_model_i (.sys_clk_i(sys_clk_i), .idx_i(s_idx), .raise_i(s_up),
    .drop_i(s_dn), .irq_o(src));
  dcir_top dcir_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .irq_src_i(src),
    .dbg_syscall_req_i(dbg_req), .deep_sleep_i(sleep), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_core_i(core), .bus_rdata_o(rdata),
    .main_cpu_irq_o(main_irq), .main_cpu_best_o(main_best), .main_cpu_nmi_o(main_nmi),
    .secondary_cpu_irq_o(sec_irq), .secondary_cpu_sw_irq_o(sw_irq),
    .secondary_cpu_best_o(sec_best), .secondary_cpu_nmi_o(sec_nmi), .wake_o(wake),
    .main_cpu_ipc_irq_o(m_ipc), .secondary_cpu_ipc_irq_o(s_ipc));
  task automatic chk(input logic [167:0] g, input logic [167:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic c = 1'b0);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    core <= dcir_pkg::dcir_core_type'(c);
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic c = 1'b0);
    @(posedge sys_clk_i);
    addr <= a;
    core <= dcir_pkg::dcir_core_type'(c);
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic src_set(input logic [7:0] i, input logic up);
    @(posedge sys_clk_i);
    s_idx <= i;
    s_up <= up;
    s_dn <= !up;
    @(posedge sys_clk_i);
    s_up <= 1'b0;
    s_dn <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic t_main;
    wr_reg(12'h000, 32'h0000_0005);
    wr_reg(12'h050, 32'h2000_0000);
    src_set(8'd0, 1'b1);
    src_set(8'd167, 1'b1);
    chk(main_irq, {1'b1, 166'h0, 1'b1});
    chk(main_best, {1'b1, 8'd167, 3'd2});
    src_set(8'd167, 1'b0);
    chk(main_best, {1'b1, 8'd0, 3'd5});
    src_set(8'd0, 1'b0);
  endtask
  task automatic t_sec;
    wr_reg(12'h160, 32'h0000_0020);
    wr_reg(12'h164, 32'h0000_0100);
    src_set(8'd40, 1'b1);
    chk(sec_irq, 8'h08);
    src_set(8'd5, 1'b1);
    src_set(8'd40, 1'b0);
    chk(sec_irq, 8'h08);
    src_set(8'd5, 1'b0);
    chk(sec_irq, 8'h00);
  endtask
  task automatic t_sw;
    wr_reg(12'h080, 32'h0003_0000);
    wr_reg(12'h084, 32'h0000_0081);
    rd_reg(12'h088);
    chk(sw_irq, 8'h81);
    chk(sec_best, 7'h7c);
    wr_reg(12'h088, 32'h0000_0080);
    rd_reg(12'h084);
    chk(got, 32'h1);
    wr_reg(12'h088, 32'h0000_0001);
  endtask
  task automatic t_nmi;
    // slot 0 points past the last source and must select nothing
    wr_reg(12'h08c, 32'h0009_00ff);
    wr_reg(12'h090, 32'h0000_0005);
    src_set(8'd9, 1'b1);
    chk(main_nmi, 1'b1);
    wr_reg(12'h090, 32'h0000_0001);
    src_set(8'd9, 1'b1);
    chk(main_nmi, 1'b0);
    src_set(8'd9, 1'b0);
    @(posedge sys_clk_i);
    dbg_req <= 1'b1;
    @(posedge sys_clk_i);
    dbg_req <= 1'b0;
    #1 chk(sec_nmi, 1'b1);
    wr_reg(12'h0a8, 32'h0000_0001);
    rd_reg(12'h0a4);
    chk(sec_nmi, 1'b0);
    chk(got, 32'h0);
    wr_reg(12'h0a4, 32'h0000_0001, 1'b1);
    rd_reg(12'h0ac);
    chk(got, 32'h0008_0000);
    chk(sec_nmi, 1'b1);
    wr_reg(12'h0a8, 32'h0000_0001);
    wr_reg(12'h094, 32'h0000_0026);
    wr_reg(12'h098, 32'h0000_0001);
    @(posedge sys_clk_i);
    sleep <= 1'b1;
    wr_reg(12'h0a0, 32'h0000_0040);
    src_set(8'd38, 1'b1);
    chk(wake, 1'b1);
    chk(sec_nmi, 1'b1);
    src_set(8'd38, 1'b0);
    chk(wake, 1'b0);
    chk(sec_nmi, 1'b0);
  endtask
  task automatic t_ipc;
    rd_reg(12'h210);
    chk(got, 32'h3);
    rd_reg(12'h210, 1'b1);
    chk(got, 32'h2);
    wr_reg(12'h218, 32'h0000_00aa);
    wr_reg(12'h218, 32'h0000_0055, 1'b1);
    rd_reg(12'h218);
    chk(got, 32'haa);
    wr_reg(12'h324, 32'h2);
    wr_reg(12'h328, 32'h1);
    wr_reg(12'h214, 32'h12, 1'b1);
    src_set(8'd1, 1'b0);
    chk(s_ipc, 16'h0);
    wr_reg(12'h214, 32'h12);
    src_set(8'd1, 1'b0);
    chk(s_ipc, 16'h4);
    rd_reg(12'h210, 1'b1);
    chk(got[2:0], 3'h7);
    rd_reg(12'h210);
    chk(got, 32'h6);
    wr_reg(12'h334, 32'h1);
    wr_reg(12'h20c, 32'h3, 1'b1);
    src_set(8'd1, 1'b0);
    chk(m_ipc, 16'h8);
    wr_reg(12'h330, 32'h1);
    rd_reg(12'h0f0);
    chk(got, 32'h0);
    chk(m_ipc, 16'h0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_main();
    t_sec();
    t_sw();
    t_nmi();
    t_ipc();
    conclude();
  end
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule
